/* File: core/adcsc_pkg.sv */
package adcsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Control byte layout
    localparam int CTRL_W      = 8;
    localparam int CTRL_SEL_HI = 6;
    localparam int CTRL_SEL_MD = 5;
    localparam int CTRL_SEL_LO = 4;
    localparam int CTRL_UNI    = 3;
    localparam int CTRL_SGL    = 2;
    localparam int CTRL_MODE_H = 1;
    localparam int CTRL_MODE_L = 0;

    // Mode bit codes
    localparam logic [1:0] MODE_EXT_CLK  = 2'h3;
    localparam logic [1:0] MODE_INT_CLK  = 2'h2;
    localparam logic [1:0] MODE_FAST_PD  = 2'h1;
    localparam logic [1:0] MODE_FULL_PD  = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Result word: ten data bits then two sub-LSB bits
    localparam int          RES_W      = 12;
    localparam logic [3:0]  RES_MSB    = 4'hb;
    localparam logic [3:0]  RES_B3_PTR = 4'h5;
    localparam logic [11:0] BIP_MASK   = 12'h800;

    // Input counter value from which the last three control bits are taken
    localparam logic [3:0]  ACQ_FIRST  = 4'h5;
    localparam logic [3:0]  CTRL_LAST  = 4'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Timing at the system clock
    localparam int CLK_PERIOD_NS   = 10;
    localparam int INT_CONV_NS     = 7500;
    localparam int STROBE_MAX_NS   = 10000;
    localparam int INT_CONV_CYC    = (INT_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_MAX_CYC  = STROBE_MAX_NS / CLK_PERIOD_NS;

    // Reset values
    localparam logic RST_EXT_CLK = 1'b0;
    localparam logic RST_STROBE  = 1'b1;

    // Output side states
    typedef enum logic [1:0] {
        OUT_IDLE   = 2'b00,
        OUT_STROBE = 2'b01,
        OUT_BITS   = 2'b11,
        OUT_WAIT   = 2'b10
    } adcsc_out_t;

endpackage

/* File: core/adcsc_conv_if.sv */
`timescale 1ns/1ps
interface adcsc_conv_if;
    logic        req_tgl;
    logic        bipolar;
    logic        done_tgl;
    logic        busy;
    logic [11:0] result;

    modport link (output req_tgl, output bipolar, input done_tgl, input busy, input result);
    modport conv (input req_tgl, input bipolar, output done_tgl, output busy, output result);
endinterface

/* File: core/adcsc_sync.sv */
`timescale 1ns/1ps
module adcsc_sync #(
    parameter int W = 1
) (
    input  logic         clk,
    input  logic         rst,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Two stages; only the second stage is read outside
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

/* File: core/adcsc_int_conv.sv */
`timescale 1ns/1ps
module adcsc_int_conv #(
    parameter int CONV_CYC = adcsc_pkg::INT_CONV_CYC
) (
    input  logic                         clk,
    input  logic                         sys_rst,
    input  logic [adcsc_pkg::RES_W-1:0]  analog_code,
    adcsc_conv_if.conv                   cv
);
    localparam int LOW_MAX = adcsc_pkg::STROBE_MAX_CYC;

    logic        req_s;
    logic [11:0] code_s;
    logic        req_seen_q, req_seen_d;
    logic        busy_q,     busy_d;
    logic        bip_q,      bip_d;
    logic        done_q,     done_d;
    logic [11:0] cnt_q,      cnt_d;
    logic [11:0] result_q,   result_d;

    // Request toggle and comparator code enter this domain here
    adcsc_sync #(.W(13)) u_sync (
        .clk (clk),
        .rst (sys_rst),
        .d   ({cv.req_tgl, analog_code}),
        .q   ({req_s, code_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Conversion timer; a new request aborts and restarts
    always_comb begin
        req_seen_d = req_seen_q;
        busy_d     = busy_q;
        bip_d      = bip_q;
        done_d     = done_q;
        cnt_d      = cnt_q;
        result_d   = result_q;
        if (req_s != req_seen_q) begin
            req_seen_d = req_s;
            busy_d     = 1'b1;
            bip_d      = cv.bipolar;
            cnt_d      = 12'(CONV_CYC - 1);
        end else if (busy_q) begin
            if (cnt_q == 12'h000) begin
                busy_d   = 1'b0;
                result_d = code_s ^ (bip_q ? adcsc_pkg::BIP_MASK : 12'h000);
                done_d   = ~done_q;
            end else begin
                cnt_d = cnt_q - 12'h001;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_seen_q <= 1'b0;
            busy_q     <= 1'b0;
            bip_q      <= 1'b0;
            done_q     <= 1'b0;
            cnt_q      <= 12'h000;
            result_q   <= 12'h000;
        end else begin
            req_seen_q <= req_seen_d;
            busy_q     <= busy_d;
            bip_q      <= bip_d;
            done_q     <= done_d;
            cnt_q      <= cnt_d;
            result_q   <= result_d;
        end
    end

    // Result word is held stable until the next done toggle
    assign cv.busy     = busy_q;
    assign cv.done_tgl = done_q;
    assign cv.result   = result_q;

    ////////////////////////////////////////////////////////////////////////////
    chk_strobe_low_max: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(busy_q) |-> ##[1:LOW_MAX] !busy_q)
        else $error("internal conversion ran too long");
    chk_result_format: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(busy_q) |-> result_q == ($past(code_s) ^ ($past(bip_q) ? 12'h800 : 12'h000)))
        else $error("result coding wrong");
    cov_int_done: cover property (@(posedge clk) disable iff (sys_rst) $fell(busy_q));
endmodule

/* File: core/adcsc_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - capture data input on each rising clock
// - leading zeros ignored; first one starts byte
// - conversion starts on fall after eighth bit
// - start accepted when idle or after bit three
// - chip select restart aborts running conversion
// - data and external mode strobe change on falling edges
// - unipolar straight binary, bipolar twos complement
// - track during last three control bits
// - external mode strobe high one clock
// - twelve result bits on following falling edges
// - external mode tristate outputs while deselected
// - internal mode strobe low while converting
// - internal result held, read out MSB first
// - deselect blocks input, keeps conversion running
// - internal mode strobe stays driven when deselected
// - result bytes carry zero padding around bits
// - all-ones input gives continuous channel seven conversions
// - control byte field layout
// - mode bit decode
module adcsc_top (
    input  logic        clk,
    input  logic        sys_rst,
    input  logic        sclk,
    input  logic        cs_n,
    input  logic        din,
    input  logic [11:0] analog_code,
    output logic        data_out,
    output logic        data_out_oe,
    output logic        conversion_strobe,
    output logic        conversion_strobe_oe,
    output logic        channel_select_hi,
    output logic        channel_select_mid,
    output logic        channel_select_lo,
    output logic        polarity_select,
    output logic        input_config_select,
    output logic        mode_bit_hi,
    output logic        mode_bit_lo,
    output logic        track_hold,
    output logic        power_down
);
    adcsc_conv_if cv ();

    logic [11:0]            code_s;
    logic                   done_s;
    logic                   frame_rst;
    logic                   accept;
    logic                   new_byte;
    // Rising side
    logic [3:0]             in_cnt_q,   in_cnt_d;
    logic                   armed_q,    armed_d;
    logic [7:0]             ctrl_sr_q,  ctrl_sr_d;
    logic [7:0]             ctrl_q,     ctrl_d;
    logic                   byte_tgl_q, byte_tgl_d;
    logic [11:0]            code_q,     code_d;
    logic                   ext_clk_q,  ext_clk_d;
    logic                   track_q,    track_d;
    logic                   pd_q,       pd_d;
    // Falling side
    adcsc_pkg::adcsc_out_t  out_st_q,   out_st_d;
    logic [3:0]             bit_ptr_q,  bit_ptr_d;
    logic [11:0]            res_q,      res_d;
    logic                   dout_q,     dout_d;
    logic                   ext_stb_q,  ext_stb_d;
    logic                   byte_seen_q, byte_seen_d;
    logic                   req_tgl_q,  req_tgl_d;
    logic                   done_seen_q, done_seen_d;
    // System clock side
    logic                   sel_s, ext_s, ext_stb_s;
    logic                   stb_q, stb_d;
    logic                   stb_oe_q, stb_oe_d;
    logic                   dout_oe_q, dout_oe_d;

    ////////////////////////////////////////////////////////////////////////////
    // Comparator code and done toggle into the link domain
    adcsc_sync #(.W(13)) u_sync_link (
        .clk (sclk),
        .rst (sys_rst),
        .d   ({cv.done_tgl, analog_code}),
        .q   ({done_s, code_s})
    );

    // Select and mode levels into the system domain; select is carried
    // active high so cleared stages read as deselected after reset
    adcsc_sync #(.W(3)) u_sync_sys (
        .clk (clk),
        .rst (sys_rst),
        .d   ({~cs_n, ext_clk_q, ext_stb_q}),
        .q   ({sel_s, ext_s, ext_stb_s})
    );

    adcsc_int_conv u_conv (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .analog_code (analog_code),
        .cv          (cv)
    );

    assign cv.req_tgl = req_tgl_q;
    assign cv.bipolar = ~ctrl_q[adcsc_pkg::CTRL_UNI];

    ////////////////////////////////////////////////////////////////////////////
    // Input side: start detection and control byte shifting on rising edges
    // Deselect clears the frame asynchronously since the link clock may stop
    assign frame_rst = sys_rst | cs_n;
    assign accept    = armed_q || (out_st_q == adcsc_pkg::OUT_IDLE)
                    || (out_st_q == adcsc_pkg::OUT_BITS && bit_ptr_q <= adcsc_pkg::RES_B3_PTR);

    always_comb begin
        in_cnt_d   = in_cnt_q;
        armed_d    = armed_q;
        ctrl_sr_d  = ctrl_sr_q;
        ctrl_d     = ctrl_q;
        byte_tgl_d = byte_tgl_q;
        code_d     = code_q;
        ext_clk_d  = ext_clk_q;
        pd_d       = pd_q;
        if (in_cnt_q == 4'h0) begin
            if (!cs_n && din && accept) begin
                ctrl_sr_d = {ctrl_sr_q[6:0], din};
                in_cnt_d  = 4'h1;
                armed_d   = 1'b0;
            end
        end else begin
            ctrl_sr_d = {ctrl_sr_q[6:0], din};
            if (in_cnt_q == adcsc_pkg::CTRL_LAST) begin
                in_cnt_d   = 4'h0;
                ctrl_d     = {ctrl_sr_q[6:0], din};
                byte_tgl_d = ~byte_tgl_q;
                code_d     = code_s;
                // Power-down codes keep the last clock mode
                if (ctrl_sr_q[0]) begin
                    ext_clk_d = din;
                end
                pd_d = ~ctrl_sr_q[0];
            end else begin
                in_cnt_d = in_cnt_q + 4'h1;
            end
        end
        track_d = (in_cnt_d >= adcsc_pkg::ACQ_FIRST);
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            in_cnt_q <= 4'h0;
            armed_q  <= 1'b1;
            track_q  <= 1'b0;
        end else begin
            in_cnt_q <= in_cnt_d;
            armed_q  <= armed_d;
            track_q  <= track_d;
        end
    end

    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_sr_q  <= 8'h00;
            ctrl_q     <= 8'h00;
            byte_tgl_q <= 1'b0;
            code_q     <= 12'h000;
            ext_clk_q  <= adcsc_pkg::RST_EXT_CLK;
            pd_q       <= 1'b0;
        end else begin
            ctrl_sr_q  <= ctrl_sr_d;
            ctrl_q     <= ctrl_d;
            byte_tgl_q <= byte_tgl_d;
            code_q     <= code_d;
            ext_clk_q  <= ext_clk_d;
            pd_q       <= pd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output side: strobe and result bits on falling edges
    // A fresh control byte wins over any shifting, which gives the restart
    assign new_byte = (byte_tgl_q != byte_seen_q);

    always_comb begin
        out_st_d    = out_st_q;
        bit_ptr_d   = bit_ptr_q;
        res_d       = res_q;
        dout_d      = dout_q;
        ext_stb_d   = ext_stb_q;
        byte_seen_d = byte_seen_q;
        req_tgl_d   = req_tgl_q;
        done_seen_d = done_seen_q;
        if (new_byte) begin
            byte_seen_d = byte_tgl_q;
            dout_d      = 1'b0;
            if (ext_clk_q) begin
                out_st_d  = adcsc_pkg::OUT_STROBE;
                ext_stb_d = 1'b1;
                res_d     = code_q ^ (ctrl_q[adcsc_pkg::CTRL_UNI] ? 12'h000 : adcsc_pkg::BIP_MASK);
            end else begin
                out_st_d  = adcsc_pkg::OUT_WAIT;
                ext_stb_d = 1'b0;
                req_tgl_d = ~req_tgl_q;
            end
        end else begin
            unique case (out_st_q)
                adcsc_pkg::OUT_IDLE: begin
                    dout_d = 1'b0;
                end
                adcsc_pkg::OUT_STROBE: begin
                    ext_stb_d = 1'b0;
                    out_st_d  = adcsc_pkg::OUT_BITS;
                    bit_ptr_d = adcsc_pkg::RES_MSB;
                    dout_d    = res_q[adcsc_pkg::RES_MSB];
                end
                adcsc_pkg::OUT_WAIT: begin
                    // Word is stable once the done toggle has crossed
                    if (done_s != done_seen_q) begin
                        done_seen_d = done_s;
                        res_d       = cv.result;
                        dout_d      = cv.result[adcsc_pkg::RES_MSB];
                        bit_ptr_d   = adcsc_pkg::RES_MSB;
                        out_st_d    = adcsc_pkg::OUT_BITS;
                    end
                end
                adcsc_pkg::OUT_BITS: begin
                    if (bit_ptr_q == 4'h0) begin
                        out_st_d = adcsc_pkg::OUT_IDLE;
                        dout_d   = 1'b0;
                    end else begin
                        bit_ptr_d = bit_ptr_q - 4'h1;
                        dout_d    = res_q[bit_ptr_q - 4'h1];
                    end
                end
            endcase
        end
    end

    // Falling edge only, so the data pin moves on the host's shift edge; the strobe pin follows after re-timing on clk
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_st_q    <= adcsc_pkg::OUT_IDLE;
            bit_ptr_q   <= 4'h0;
            res_q       <= 12'h000;
            dout_q      <= 1'b0;
            ext_stb_q   <= 1'b0;
            byte_seen_q <= 1'b0;
            req_tgl_q   <= 1'b0;
            done_seen_q <= 1'b0;
        end else begin
            out_st_q    <= out_st_d;
            bit_ptr_q   <= bit_ptr_d;
            res_q       <= res_d;
            dout_q      <= dout_d;
            ext_stb_q   <= ext_stb_d;
            byte_seen_q <= byte_seen_d;
            req_tgl_q   <= req_tgl_d;
            done_seen_q <= done_seen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers; internal conversion never looks at chip select
    always_comb begin
        dout_oe_d = sel_s;
        if (ext_s) begin
            stb_d    = ext_stb_s;
            stb_oe_d = sel_s;
        end else begin
            stb_d    = ~cv.busy;
            stb_oe_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stb_q     <= adcsc_pkg::RST_STROBE;
            stb_oe_q  <= 1'b1;
            dout_oe_q <= 1'b0;
        end else begin
            stb_q     <= stb_d;
            stb_oe_q  <= stb_oe_d;
            dout_oe_q <= dout_oe_d;
        end
    end

    assign data_out             = dout_q;
    assign data_out_oe          = dout_oe_q;
    assign conversion_strobe    = stb_q;
    assign conversion_strobe_oe = stb_oe_q;
    assign channel_select_hi    = ctrl_q[adcsc_pkg::CTRL_SEL_HI];
    assign channel_select_mid   = ctrl_q[adcsc_pkg::CTRL_SEL_MD];
    assign channel_select_lo    = ctrl_q[adcsc_pkg::CTRL_SEL_LO];
    assign polarity_select      = ctrl_q[adcsc_pkg::CTRL_UNI];
    assign input_config_select  = ctrl_q[adcsc_pkg::CTRL_SGL];
    assign mode_bit_hi          = ctrl_q[adcsc_pkg::CTRL_MODE_H];
    assign mode_bit_lo          = ctrl_q[adcsc_pkg::CTRL_MODE_L];
    assign track_hold           = track_q;
    assign power_down           = pd_q;

    ////////////////////////////////////////////////////////////////////////////
    chk_shift_capture: assert property (@(posedge sclk) disable iff (frame_rst)
        (in_cnt_q != 4'h0) |=> ctrl_sr_q[0] == $past(din))
        else $error("data bit not captured");
    chk_zero_ignored: assert property (@(posedge sclk) disable iff (frame_rst)
        (in_cnt_q == 4'h0 && !din) |=> in_cnt_q == 4'h0)
        else $error("zero bit started a byte");
    chk_start_window: assert property (@(posedge sclk) disable iff (frame_rst)
        (in_cnt_q == 4'h0 && !armed_q && out_st_q == adcsc_pkg::OUT_BITS
         && bit_ptr_q > adcsc_pkg::RES_B3_PTR) |=> in_cnt_q == 4'h0)
        else $error("start taken before bit three");
    chk_ext_start: assert property (@(negedge sclk) disable iff (sys_rst)
        (new_byte && ext_clk_q) |=> ext_stb_q ##1 (!ext_stb_q && dout_q == $past(res_q[11])))
        else $error("strobe pulse not one clock");
    chk_twelve_bits: assert property (@(negedge sclk) disable iff (frame_rst)
        $fell(ext_stb_q) |-> bit_ptr_q == 4'hb ##11 (bit_ptr_q == 4'h0 && out_st_q == adcsc_pkg::OUT_BITS))
        else $error("result bit count wrong");
    chk_acquire: assert property (@(posedge sclk) disable iff (frame_rst)
        $rose(track_q) |-> track_q [*3] ##1 !track_q)
        else $error("acquisition not three bits");
    chk_int_request: assert property (@(negedge sclk) disable iff (sys_rst)
        (new_byte && !ext_clk_q) |=> (out_st_q == adcsc_pkg::OUT_WAIT && req_tgl_q != $past(req_tgl_q)))
        else $error("internal conversion not requested");
    chk_dout_tristate: assert property (@(posedge clk) disable iff (sys_rst)
        !sel_s |=> !data_out_oe)
        else $error("data driven while deselected");
    chk_strobe_kept: assert property (@(posedge clk) disable iff (sys_rst)
        !ext_s |=> (conversion_strobe_oe && conversion_strobe == !$past(cv.busy)))
        else $error("internal strobe not driven");
    chk_ext_strobe_off: assert property (@(posedge clk) disable iff (sys_rst)
        (ext_s && !sel_s) |=> !conversion_strobe_oe)
        else $error("external strobe driven while deselected");
    chk_ext_strobe_low: assert property (@(posedge clk) disable iff (sys_rst)
        (ext_s && $rose(sel_s) && !ext_stb_s) |=> (conversion_strobe_oe && !conversion_strobe))
        else $error("external strobe not low after select");
    cov_ext_conv: cover property (@(negedge sclk) disable iff (sys_rst) $fell(ext_stb_q));
    cov_restart: cover property (@(posedge sclk) disable iff (frame_rst)
        armed_q && out_st_q == adcsc_pkg::OUT_BITS && din && in_cnt_q == 4'h0);
    cov_int_read: cover property (@(negedge sclk) disable iff (sys_rst)
        out_st_q == adcsc_pkg::OUT_WAIT ##1 out_st_q == adcsc_pkg::OUT_BITS);
endmodule

/* File: verification/adcsc_host.sv */
`timescale 1ns/1ps
module adcsc_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic data_out
);
    localparam int HALF_NS = 80; // scaled for run time; strobe re-timing needs a clock period longer than the system clock's

    // Extra low time before the last three bits of a frame
    int acq_gap_ns = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Idle: clock parked low, deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // Mode zero frame; the clock only runs inside frames, so each
    // conversion stays far below the droop limit
    task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx   = '0;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            din = tx[i];
            if (i < 3 && acq_gap_ns > 0) begin
                #(acq_gap_ns);
            end
            #(HALF_NS);
            sclk = 1'b1;
            rx   = {rx[30:0], data_out};
            #(HALF_NS);
            sclk = 1'b0;
        end
    endtask

    // Deselect, then leave a gap longer than the pin re-timing
    task automatic release_cs();
        #(HALF_NS);
        cs_n = 1'b1;
        din  = ~din;
        #(4 * HALF_NS);
    endtask
endmodule

/* File: verification/tb_adcsc_top.sv */
`timescale 1ns/1ps
module tb_adcsc_top;
    typedef struct {logic [7:0] ctrl; logic [11:0] code; logic [15:0] reply;} adcsc_row_t;
    logic        clk;
    logic        sys_rst;
    logic [11:0] analog_code;
    logic        sclk, cs_n, din, data_out, data_out_oe, strobe, strobe_oe, track_hold, power_down;
    logic [6:0]  fields;
    logic [31:0] rx;
    logic        dout_seen;
    int          miscompares, checks_done, cyc, rises, n, trk;
    adcsc_row_t  rows[5] = '{'{8'hFF, 12'hA5C, 16'h52E0}, '{8'h8F, 12'h123, 16'h0918},
        '{8'hB3, 12'h801, 16'h0008}, '{8'hC7, 12'h7FF, 16'h7FF8}, '{8'hF9, 12'h3C0, 16'h1E00}};

    adcsc_top dut_u (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .analog_code(analog_code), .data_out(data_out), .data_out_oe(data_out_oe),
        .conversion_strobe(strobe), .conversion_strobe_oe(strobe_oe),
        .channel_select_hi(fields[6]), .channel_select_mid(fields[5]), .channel_select_lo(fields[4]),
        .polarity_select(fields[3]), .input_config_select(fields[2]), .mode_bit_hi(fields[1]),
        .mode_bit_lo(fields[0]), .track_hold(track_hold), .power_down(power_down));
    adcsc_host host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .data_out(dout_seen));

    // Host sees the inverse of the last bit while the pin floats
    assign dout_seen = data_out_oe ? data_out : ~data_out;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, timeout and strobe edge count
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            wrap_up();
        end
    end
    always @(posedge strobe) rises++;
    always @(posedge clk) begin
        if (track_hold) begin
            trk++;
        end
    end

    task automatic check(input string name, input logic [31:0] want, input logic [31:0] got);
        checks_done++;
        if (got !== want) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, want, got);
        end
    endtask

    // Three-byte external readout after leading zeros
    task automatic run_row(input adcsc_row_t r);
        @(posedge clk);
        #1 analog_code = r.code;
        host_u.shift({4'h0, r.ctrl, 16'h0000}, 28, rx);
        check("reply", r.reply, rx[15:0]);
        check("fields", r.ctrl[6:0], fields);
        check("power_down", !r.ctrl[1], power_down);
        host_u.release_cs();
        check("oe", 0, {data_out_oe, strobe_oe});
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        sys_rst     = 1'b1;
        analog_code = 12'h000;
        repeat (10) @(posedge clk);
        check("reset", 32'h0000_0006, {data_out_oe, strobe, strobe_oe, power_down});
        #1 sys_rst = 1'b0;
        repeat (5) @(posedge clk);
        foreach (rows[i]) run_row(rows[i]);
        // Restart before bit three is taken after a deselect
        host_u.shift({8'hFF, 1'b0}, 9, rx);
        host_u.release_cs();
        run_row('{8'h8F, 12'h0F0, 16'h0780});
        // Data input held high: one conversion per 15 clocks
        rises = 0;
        host_u.shift(32'hFFFF_FFFF, 30, rx);
        host_u.shift(32'hFFFF_FFFF, 15, rx);
        check("rate", 3, rises);
        // Clock kept running: sixteen zeros make the next start certain
        host_u.shift({16'h0000, 8'h8F}, 24, rx);
        host_u.shift(32'h0, 16, rx);
        check("resync", 16'h0780, rx[15:0]);
        host_u.release_cs();
        // Internal mode survives deselect, result held for later
        analog_code = 12'h5A3;
        trk = 0;
        host_u.acq_gap_ns = 500;
        host_u.shift(32'h0000_008E, 8, rx);
        host_u.acq_gap_ns = 0;
        // Three stretched bit periods of 660 ns each
        check("track", 198, trk);
        n = 0;
        while (strobe !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check("strobe_low", 1, n < 100);
        host_u.release_cs();
        check("deselect", 3'b001, {data_out_oe, strobe, strobe_oe});
        n = 0;
        while (strobe !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check("strobe_len", 1, n + 40 <= adcsc_pkg::STROBE_MAX_CYC);
        host_u.shift(32'h0, 16, rx);
        check("held", 12'h5A3, rx[13:2]);
        host_u.release_cs();
        wrap_up();
    end
endmodule
